// *** rtl/asfc_pkg.sv ***
// shared constants and carriers of the serial flow control block
// assumes a classic wishbone master with byte addressing, 8-bit registers
package asfc_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_OPT2 = 8'h04;
  localparam logic [7:0] ADR_OPT3 = 8'h08;
  localparam logic [7:0] ADR_OPT4 = 8'h0c;
  localparam logic [7:0] ADR_OPT5 = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [7:0] ADR_SPECIAL_TX_COMMAND_REG = 8'h18;
  localparam logic [7:0] ADR_SPC1 = 8'h1c;
  localparam logic [7:0] ADR_SPC4 = 8'h28;
  localparam logic [7:0] ADR_MDM = 8'h2c;
  // field positions
  localparam int B_TXEN = 0;
  localparam int B_RXEN = 1;
  localparam int B_AUTO = 2;
  localparam int B_MODE = 4;
  localparam int B_CLEAR_TO_SEND_AUTO_ENABLE = 1;
  localparam int B_TX_INBAND_ENABLE = 6;
  localparam int B_IXM = 7;
  localparam int B_SCDE = 4;
  localparam int B_FCT = 5;
  localparam int B_TXOFF = 2;
  localparam int B_TXON = 1;
  localparam int B_RXON = 3;
  localparam int B_RXOFF = 4;
  localparam int B_SND = 3;
  localparam int B_MRTS = 0;
  localparam int B_MDTR = 1;
  localparam int B_MCTS = 2;
  localparam int B_MDSR = 3;
  // values after reset
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RST_MDM = 2'h0;

  typedef enum logic [2:0] {
    MODE_ASYNC = 3'b000,
    MODE_PPP = 3'b001,
    MODE_SLIP = 3'b010,
    MODE_ERRCTL = 3'b011,
    MODE_SYNC = 3'b100
  } asfc_mode_t;

  typedef enum logic [0:0] {
    SP_IDLE = 1'b0,
    SP_BUSY = 1'b1
  } asfc_sp_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } asfc_wbreq_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } asfc_wbrsp_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [7:0] data;
  } asfc_rxchar_t;
endpackage

// *** rtl/asfc_flow.sv ***
// per-channel xon/xoff and modem-pin flow control with wishbone registers
// assumes the transmitter and receive fifo sit on core_clk; modem pins async
// Behaviour
// - transmit in-band flow control acts only while option two bit 6 is set.
// - implied resume mode bit 7 is ignored while in-band transmit is off.
// - xon and xoff codes come from special character registers one and two.
// - xoff stops loading; shift and holding characters still go out.
// - resume on xon, or on any error-free character but xoff when implied resume is set.
// - transparency bit 5 withholds flow characters, else pass as exception.
// - tx flow off status set by remote stop, cleared on restart or enable change.
// - tx flow on status set by remote restart, cleared once transmission resumes.
// - send special command transmits the selected special character, one to four.
// - rx flow off set when xoff sent, cleared on xon or receiver change.
// - rx flow on set when xon sent, cleared on next plain received character.
// - auto mode sends xoff when fifo count exceeds the threshold.
// - auto mode sends xon at or below threshold only after an auto xoff.
// - auto in-band flow control only in async and async ppp modes.
// - with cts auto enable, loading waits for cts low.
// - async: cts high stops after shift and holding stages drain.
// - sync mode (MODE_SYNC only): cts high stops only at the end of the current frame.
// - nonzero option five xoff threshold drives dtr high when both thresholds exceeded.
// - auto dtr returns low once fifo content falls below the option five xoff threshold.
// - without auto control the four modem pins are general purpose.
// - auto control ties rts/cts to transmitter and dtr/dsr to receiver; dsr is only read back in the modem register here.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module asfc_flow
  import asfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire asfc_wbreq_t wbReq,
  output asfc_wbrsp_t wbRsp,
  input wire asfc_rxchar_t rxChar,
  input wire logic [4:0] rxFifoCount,
  input wire logic txPending,
  input wire logic txLoadStrobe,
  input wire logic txInFrame,
  output logic txLoadEnable,
  output logic specialReq,
  output logic [7:0] specialChar,
  input wire logic specialDone,
  output logic rxDeliver,
  output logic rxException,
  output logic [7:0] rxData,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic rts_n,
  output logic dtr_n
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] ctrl;
    logic [7:0] opt2;
    logic [7:0] opt3;
    logic [7:0] opt4;
    logic [7:0] opt5;
    logic [7:0] special_tx_command_reg;
    logic [3:0][7:0] spc;
    logic [1:0] mdm;
    logic txOff;
    logic txOn;
    logic rxOff;
    logic rxOn;
    logic xoffSent;
    asfc_sp_t sp;
    logic [7:0] spChar;
    logic spXon;
    logic spXoff;
    logic spHost;
    logic ctsMeta;
    logic ctsSync;
    logic dsrMeta;
    logic dsrSync;
    logic ctsBlock;
    logic dtrHigh;
    logic rtsOut;
    logic dtrOut;
    logic rxPass;
    logic rxExc;
    logic [7:0] rxWord;
    logic txEnPrev;
    logic rxEnPrev;
  } asfc_state_t;

  asfc_state_t q;
  asfc_state_t d;

  function automatic logic asfc_inband_mode(input logic [2:0] m);
    asfc_inband_mode = (m == MODE_ASYNC) || (m == MODE_PPP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic busWr;
  logic busRd;
  logic [2:0] mode;
  logic inbandTx;
  logic autoOn;
  logic isXon;
  logic isXoff;
  logic flowChar;
  logic goodChar;
  logic overThr;
  logic autoDtr;
  logic [1:0] spIdx;
  logic txEnChg;
  logic rxEnChg;

  always_comb
  begin
    d = q;
    busWr = wbReq.cyc && wbReq.stb && wbReq.we && !q.ack && wbReq.sel[0];
    busRd = wbReq.cyc && wbReq.stb && !wbReq.we && !q.ack;
    mode = q.ctrl[B_MODE +: 3];
    txEnChg = q.ctrl[B_TXEN] != q.txEnPrev;
    rxEnChg = q.ctrl[B_RXEN] != q.rxEnPrev;
    d.txEnPrev = q.ctrl[B_TXEN];
    d.rxEnPrev = q.ctrl[B_RXEN];
    // in-band control needs detection on and a mode that allows it
    inbandTx = q.opt2[B_TX_INBAND_ENABLE] && q.opt3[B_SCDE] && asfc_inband_mode(mode);
    autoOn = q.ctrl[B_AUTO] && q.opt3[B_SCDE] && asfc_inband_mode(mode);
    goodChar = rxChar.valid && !rxChar.error;
    isXon = goodChar && q.opt3[B_SCDE] && (rxChar.data == q.spc[0]);
    isXoff = goodChar && q.opt3[B_SCDE] && (rxChar.data == q.spc[1]);
    flowChar = isXon || isXoff;
    overThr = rxFifoCount > {1'b0, q.opt5[3:0]};
    autoDtr = q.opt5[3:0] != 4'h0;
    spIdx = 2'(q.special_tx_command_reg[2:0] - 3'h1);

    // receive path delivery
    d.rxPass = rxChar.valid && !(flowChar && q.opt3[B_FCT]);
    d.rxExc = flowChar && !q.opt3[B_FCT];
    d.rxWord = rxChar.valid ? rxChar.data : q.rxWord;

    // tx flow status: clears first, remote events after so a set wins
    if (txEnChg)
    begin
      d.txOff = 1'b0;
      d.txOn = 1'b0;
    end
    if (txLoadStrobe)
    begin
      d.txOn = 1'b0;
    end
    if (inbandTx)
    begin
      if (isXoff)
      begin
        d.txOff = 1'b1;
      end
      else if (q.txOff && (isXon || (q.opt2[B_IXM] && goodChar)))
      begin
        d.txOff = 1'b0;
        d.txOn = 1'b1;
      end
    end

    // rx flow status
    if (goodChar && !flowChar)
    begin
      d.rxOn = 1'b0;
    end
    if (rxEnChg)
    begin
      d.rxOff = 1'b0;
      d.rxOn = 1'b0;
      d.xoffSent = 1'b0;
    end

    // special character sender; host command first, automatic second
    case (q.sp)
      SP_IDLE:
      begin
        if (q.special_tx_command_reg[B_SND])
        begin
          if (q.special_tx_command_reg[2:0] != 3'h0 && q.special_tx_command_reg[2:0] <= 3'h4)
          begin
            d.sp = SP_BUSY;
            d.spChar = q.spc[spIdx];
            d.spXon = q.special_tx_command_reg[2:0] == 3'h1;
            d.spXoff = q.special_tx_command_reg[2:0] == 3'h2;
            d.spHost = 1'b1;
          end
          else
          begin
            d.special_tx_command_reg = RST_REG;
          end
        end
        else if (autoOn && !rxEnChg && overThr && !q.xoffSent)
        begin
          d.sp = SP_BUSY;
          d.spChar = q.spc[1];
          d.spXon = 1'b0;
          d.spXoff = 1'b1;
          d.spHost = 1'b0;
          d.xoffSent = 1'b1;
        end
        else if (autoOn && !rxEnChg && !overThr && q.xoffSent)
        begin
          d.sp = SP_BUSY;
          d.spChar = q.spc[0];
          d.spXon = 1'b1;
          d.spXoff = 1'b0;
          d.spHost = 1'b0;
          d.xoffSent = 1'b0;
        end
      end
      SP_BUSY:
      begin
        if (specialDone)
        begin
          d.sp = SP_IDLE;
          if (q.spHost)
          begin
            d.special_tx_command_reg = RST_REG;
          end
          // host-sent flow chars update rx status the same as automatic ones
          if (q.spXoff)
          begin
            d.rxOff = 1'b1;
            d.rxOn = 1'b0;
          end
          if (q.spXon)
          begin
            d.rxOff = 1'b0;
            d.rxOn = 1'b1;
          end
        end
      end
      default:
      begin
        d.sp = SP_IDLE;
      end
    endcase

    // modem pins: two flops before use
    d.ctsMeta = cts_n;
    d.ctsSync = q.ctsMeta;
    d.dsrMeta = dsr_n;
    d.dsrSync = q.dsrMeta;
    if (mode == MODE_SYNC)
    begin
      // frames are never cut mid-way
      if (!txInFrame)
      begin
        d.ctsBlock = q.ctsSync;
      end
    end
    else
    begin
      d.ctsBlock = q.ctsSync;
    end
    if (q.opt2[B_CLEAR_TO_SEND_AUTO_ENABLE])
    begin
      d.rtsOut = !txPending;
    end
    else
    begin
      d.rtsOut = !q.mdm[B_MRTS];
    end
    if (rxFifoCount > {1'b0, q.opt4[3:0]} && overThr)
    begin
      d.dtrHigh = 1'b1;
    end
    else if (rxFifoCount < {1'b0, q.opt5[3:0]})
    begin
      d.dtrHigh = 1'b0;
    end
    d.dtrOut = autoDtr ? q.dtrHigh : !q.mdm[B_MDTR];

    // wishbone slave: one wait state, ack for one cycle
    d.ack = wbReq.cyc && wbReq.stb && !q.ack;
    if (busWr)
    begin
      if (wbReq.adr == ADR_CTRL)
      begin
        d.ctrl = wbReq.dat[7:0];
      end
      else if (wbReq.adr == ADR_OPT2)
      begin
        d.opt2 = wbReq.dat[7:0];
      end
      else if (wbReq.adr == ADR_OPT3)
      begin
        d.opt3 = wbReq.dat[7:0];
      end
      else if (wbReq.adr == ADR_OPT4)
      begin
        d.opt4 = wbReq.dat[7:0];
      end
      else if (wbReq.adr == ADR_OPT5)
      begin
        d.opt5 = wbReq.dat[7:0];
      end
      else if (wbReq.adr == ADR_SPECIAL_TX_COMMAND_REG)
      begin
        d.special_tx_command_reg = wbReq.dat[7:0];
      end
      else if (wbReq.adr >= ADR_SPC1 && wbReq.adr <= ADR_SPC4 && wbReq.adr[1:0] == 2'h0)
      begin
        d.spc[2'(wbReq.adr[7:2] - ADR_SPC1[7:2])] = wbReq.dat[7:0];
      end
      else if (wbReq.adr == ADR_MDM)
      begin
        d.mdm = wbReq.dat[1:0];
      end
    end
    d.rdat = 32'h0000_0000;
    if (busRd)
    begin
      if (wbReq.adr == ADR_CTRL)
      begin
        d.rdat[7:0] = q.ctrl;
      end
      else if (wbReq.adr == ADR_OPT2)
      begin
        d.rdat[7:0] = q.opt2;
      end
      else if (wbReq.adr == ADR_OPT3)
      begin
        d.rdat[7:0] = q.opt3;
      end
      else if (wbReq.adr == ADR_OPT4)
      begin
        d.rdat[7:0] = q.opt4;
      end
      else if (wbReq.adr == ADR_OPT5)
      begin
        d.rdat[7:0] = q.opt5;
      end
      else if (wbReq.adr == ADR_STAT)
      begin
        d.rdat[B_TXOFF] = q.txOff;
        d.rdat[B_TXON] = q.txOn;
        d.rdat[B_RXOFF] = q.rxOff;
        d.rdat[B_RXON] = q.rxOn;
      end
      else if (wbReq.adr == ADR_SPECIAL_TX_COMMAND_REG)
      begin
        d.rdat[7:0] = q.special_tx_command_reg;
      end
      else if (wbReq.adr >= ADR_SPC1 && wbReq.adr <= ADR_SPC4 && wbReq.adr[1:0] == 2'h0)
      begin
        d.rdat[7:0] = q.spc[2'(wbReq.adr[7:2] - ADR_SPC1[7:2])];
      end
      else if (wbReq.adr == ADR_MDM)
      begin
        d.rdat[1:0] = q.mdm;
        d.rdat[B_MCTS] = !q.ctsSync;
        d.rdat[B_MDSR] = !q.dsrSync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.ctrl <= RST_REG;
      q.mdm <= RST_MDM;
      q.rtsOut <= 1'b1;
      q.dtrOut <= 1'b1;
      q.ctsMeta <= 1'b1;
      q.ctsSync <= 1'b1;
      q.ctsBlock <= 1'b1;
      q.dsrMeta <= 1'b1;
      q.dsrSync <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // gating loads only lets the shift and holding stages drain
  assign txLoadEnable = q.ctrl[B_TXEN] && !q.txOff && !(q.opt2[B_CLEAR_TO_SEND_AUTO_ENABLE] && q.ctsBlock);
  assign specialReq = q.sp == SP_BUSY;
  assign specialChar = q.spChar;
  assign rxDeliver = q.rxPass;
  assign rxException = q.rxExc;
  assign rxData = q.rxWord;
  assign rts_n = q.rtsOut;
  assign dtr_n = q.dtrOut;
  assign wbRsp.ack = q.ack;
  assign wbRsp.dat = q.rdat;

endmodule // asfc_flow

// *** sim/asfc_flow_chk.sv ***
// port assertions of the serial flow control block
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module asfc_flow_chk
  import asfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire asfc_wbreq_t wbReq,
  input wire asfc_wbrsp_t wbRsp,
  input wire asfc_rxchar_t rxChar,
  input wire logic specialReq,
  input wire logic [7:0] specialChar,
  input wire logic specialDone,
  input wire logic rxDeliver,
  input wire logic rxException,
  input wire logic [7:0] rxData,
  input wire logic rts_n,
  input wire logic dtr_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
////////////////////////////////////////
  sequence s_req;
    wbReq.cyc && wbReq.stb && !wbRsp.ack;
  endsequence
  sequence s_sent;
    specialReq && specialDone;
  endsequence
  property p_ackAnswer;
    s_req |=> wbRsp.ack;
  endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("ack missing");
  property p_ackPulse;
    wbRsp.ack |=> !wbRsp.ack;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  property p_ackCause;
    wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb);
  endproperty
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  property p_specHold;
    specialReq && !specialDone |=> specialReq && $stable(specialChar);
  endproperty
  a_specHold: assert property (p_specHold) else $error("special char dropped");
  property p_specDrop;
    s_sent |=> !specialReq;
  endproperty
  a_specDrop: assert property (p_specDrop) else $error("special req stuck");
  property p_deliver;
    rxDeliver |-> $past(rxChar.valid);
  endproperty
  a_deliver: assert property (p_deliver) else $error("delivery without char");
  property p_excPair;
    rxException |-> rxDeliver;
  endproperty
  a_excPair: assert property (p_excPair) else $error("exception not delivered");
  property p_rxData;
    rxChar.valid |=> rxData == $past(rxChar.data);
  endproperty
  a_rxData: assert property (p_rxData) else $error("rx data wrong");
  property p_rstPins;
    disable iff (1'b0) !reset_n |=> rts_n && dtr_n && !specialReq;
  endproperty
  a_rstPins: assert property (p_rstPins) else $error("reset state wrong");
endmodule // asfc_flow_chk

bind asfc_flow asfc_flow_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .wbReq(wbReq), .wbRsp(wbRsp), .rxChar(rxChar), .specialReq(specialReq),
  .specialChar(specialChar), .specialDone(specialDone), .rxDeliver(rxDeliver),
  .rxException(rxException), .rxData(rxData), .rts_n(rts_n), .dtr_n(dtr_n));

// *** sim/asfc_remote.sv ***
// transmitter stage and remote line as seen by the flow block
// assumes specialReq holds until specialDone
`timescale 1ns/1ps
module asfc_remote
(
  input wire logic core_clk,
  input wire logic specialReq,
  input wire logic [7:0] specialChar,
  input wire logic slow,
  output logic specialDone,
  output logic [7:0] lastSent,
  output int sentCount
);
  logic [7:0] cnt;
  initial
  begin
    specialDone = 1'b0;
    lastSent = 8'h00;
    sentCount = 0;
    cnt = 8'h00;
  end
  // counter keeps running past done so a held request is not sent twice
  always @(posedge core_clk)
  begin
    specialDone <= 1'b0;
    if (!specialReq)
      cnt <= 8'h00;
    else
    begin
      cnt <= cnt + 8'h01;
      if (cnt == (slow ? 8'h06 : 8'h01))
      begin
        specialDone <= 1'b1;
        lastSent <= specialChar;
        sentCount <= sentCount + 1;
      end
    end
  end
endmodule // asfc_remote

// *** sim/async_serial_flow_control_test.sv ***
// self-checking bench of the serial flow control block
// assumes the remote model answers every special char request
`timescale 1ns/1ps
module async_serial_flow_control_test
  import asfc_pkg::*;
;
  logic core_clk = 0, reset_n = 0, txPending = 0, txLoadStrobe = 0, cts_n = 1, slow = 0;
  logic txInFrame = 0, dsr_n = 1;
  asfc_wbreq_t wbReq = '0;
  asfc_wbrsp_t wbRsp;
  asfc_rxchar_t rxChar = '0;
  logic [4:0] rxFifoCount = 5'h00;
  logic txLoadEnable, specialReq, specialDone, rxDeliver, rxException, rts_n, dtr_n, dl, ex;
  logic [7:0] specialChar, lastSent, q, xon, xoff, thr, rxData, rd;
  int sentCount, k, n_mismatch = 0, tests_run = 0, cycles = 0, seed = 55102;
  asfc_flow u_dut (.core_clk(core_clk), .reset_n(reset_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .rxChar(rxChar), .rxFifoCount(rxFifoCount), .txPending(txPending),
    .txLoadStrobe(txLoadStrobe), .txInFrame(txInFrame), .txLoadEnable(txLoadEnable),
    .specialReq(specialReq), .specialChar(specialChar), .specialDone(specialDone),
    .rxDeliver(rxDeliver), .rxException(rxException), .rxData(rxData), .cts_n(cts_n),
    .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n));
  asfc_remote u_rem (.core_clk(core_clk), .specialReq(specialReq), .specialChar(specialChar),
    .slow(slow), .specialDone(specialDone), .lastSent(lastSent), .sentCount(sentCount));
////////////////////////////////////////
  initial forever #2.5 core_clk = ~core_clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do @(posedge core_clk); while (wbRsp.ack !== 1'b1 && ++n < 40);
    q = wbRsp.dat[7:0];
    if (n == 40) n_mismatch++;
    wbReq <= '0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic rx(input logic [7:0] c);
    @(posedge core_clk);
    rxChar <= '{1'b1, 1'b0, c};
    @(posedge core_clk);
    rxChar.valid <= 1'b0;
    @(posedge core_clk);
    dl = rxDeliver;
    ex = rxException;
    rd = rxData;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic waitSend();
    int n, s;
    s = sentCount;
    n = 0;
    while (sentCount == s && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 200) n_mismatch++;
    repeat (3) @(posedge core_clk);
  endtask
////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 'h30; a += 4) rdChk(8'(a), 8'h00);
    wb(1'b1, ADR_STAT, 8'hff);
    rdChk(ADR_STAT, 8'h00);
    xon = 8'($random(seed));
    xoff = xon ^ 8'h5a;
    wb(1'b1, ADR_SPC1, xon);
    wb(1'b1, ADR_SPC1 + 8'h04, xoff);
    wb(1'b1, ADR_OPT3, 8'h10);
    wb(1'b1, ADR_CTRL, 8'h03);
    slow <= 1'b1;
    wb(1'b1, ADR_SPECIAL_TX_COMMAND_REG, 8'h0a);
    waitSend();
    chk(lastSent, xoff);
    rdChk(ADR_STAT, 8'h10);
    wb(1'b1, ADR_CTRL, 8'h01);
    rdChk(ADR_STAT, 8'h00);
    wb(1'b1, ADR_CTRL, 8'h03);
    slow <= 1'b0;
    wb(1'b1, ADR_SPECIAL_TX_COMMAND_REG, 8'h09);
    waitSend();
    chk(lastSent, xon);
    rdChk(ADR_STAT, 8'h08);
    wb(1'b1, ADR_SPC4, 8'ha5);
    wb(1'b1, ADR_SPECIAL_TX_COMMAND_REG, 8'h0c);
    waitSend();
    chk(lastSent, 8'ha5);
    k = sentCount;
    wb(1'b1, ADR_SPECIAL_TX_COMMAND_REG, 8'h08);
    rdChk(ADR_SPECIAL_TX_COMMAND_REG, 8'h00);
    chk(8'(sentCount), 8'(k));
    rx(xon ^ 8'h01);
    rdChk(ADR_STAT, 8'h00);
    wb(1'b1, ADR_OPT2, 8'h40);
    txPending <= 1'b1;
    rx(xoff);
    chk({6'h0, dl, ex}, 8'h03);
    chk(rd, xoff);
    chk({7'h0, txLoadEnable}, 8'h00);
    rdChk(ADR_STAT, 8'h04);
    rx(xon ^ 8'h01);
    chk({7'h0, txLoadEnable}, 8'h00);
    rx(xon);
    chk({7'h0, txLoadEnable}, 8'h01);
    rdChk(ADR_STAT, 8'h02);
    txLoadStrobe <= 1'b1;
    @(posedge core_clk);
    txLoadStrobe <= 1'b0;
    rdChk(ADR_STAT, 8'h00);
    wb(1'b1, ADR_OPT3, 8'h30);
    rx(xoff);
    chk({6'h0, dl, ex}, 8'h00);
    rdChk(ADR_STAT, 8'h04);
    wb(1'b1, ADR_CTRL, 8'h02);
    rdChk(ADR_STAT, 8'h00);
    wb(1'b1, ADR_CTRL, 8'h03);
    rx(xoff);
    wb(1'b1, ADR_OPT2, 8'hc0);
    rx(xon ^ 8'h01);
    chk({7'h0, txLoadEnable}, 8'h01);
    wb(1'b1, ADR_OPT2, 8'h80);
    rx(xoff);
    chk({7'h0, txLoadEnable}, 8'h01);
    wb(1'b1, ADR_OPT2, 8'h02);
    repeat (6) @(posedge core_clk);
    chk({7'h0, txLoadEnable}, 8'h00);
    chk({7'h0, rts_n}, 8'h00);
    cts_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({7'h0, txLoadEnable}, 8'h01);
    wb(1'b1, ADR_CTRL, 8'h43);
    txInFrame <= 1'b1;
    cts_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({7'h0, txLoadEnable}, 8'h01);
    txInFrame <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({7'h0, txLoadEnable}, 8'h00);
    cts_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({7'h0, txLoadEnable}, 8'h01);
    wb(1'b1, ADR_OPT2, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({7'h0, rts_n}, 8'h01);
    dsr_n <= 1'b0;
    wb(1'b1, ADR_MDM, 8'h01);
    repeat (2) @(posedge core_clk);
    chk({7'h0, rts_n}, 8'h00);
    rdChk(ADR_MDM, 8'h0d);
    thr = 8'(($random(seed) & 7) + 1);
    wb(1'b1, ADR_OPT5, thr);
    wb(1'b1, ADR_CTRL, 8'h07);
    rxFifoCount <= 5'(thr) + 5'h01;
    waitSend();
    chk(lastSent, xoff);
    chk({7'h0, dtr_n}, 8'h01);
    rxFifoCount <= 5'(thr);
    waitSend();
    chk(lastSent, xon);
    rxFifoCount <= 5'(thr) - 5'h01;
    repeat (4) @(posedge core_clk);
    chk({7'h0, dtr_n}, 8'h00);
    wb(1'b1, ADR_CTRL, 8'h27);
    k = sentCount;
    rxFifoCount <= 5'(thr) + 5'h01;
    repeat (20) @(posedge core_clk);
    chk(8'(sentCount), 8'(k));
    final_report();
  end
endmodule // async_serial_flow_control_test
